// ==== logic/upps_pkg.sv ====
// upps_pkg: constants, states and carriers for the usb pll/phy power sequencer host
// assumes a simple word-wide register port into the usb subsystem (address, data, strobes)
package upps_pkg;

  // ---------------------------------------------------------------
  // register addresses of the device (word indices, chosen locally)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CLOCK_GATE_REG_SIX = 4'h0;
  localparam logic [3:0] ADDR_USB_PLL_CONTROL    = 4'h1;
  localparam logic [3:0] ADDR_PHY_CONTROL_REG    = 4'h2;
  localparam logic [3:0] ADDR_PHY_POWER_DOWN_REG = 4'h3;
  localparam logic [3:0] ADDR_PORT_STATUS_CTRL   = 4'h4;
  localparam logic [3:0] ADDR_USB_CTRL           = 4'h5;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BUS_CLK_GATE_LSB   = 0;
  localparam logic [1:0] BUS_CLK_ON_TO_STOP = 2'h3;
  localparam int PLL_ENABLE_BIT     = 13;
  localparam int PLL_POWER_BIT      = 12;
  localparam int PLL_BYPASS_BIT     = 16;
  localparam int PLL_CLK_OUT_EN_BIT = 6;
  localparam int PLL_LOCK_BIT       = 31;
  localparam int PHY_SOFT_RESET_BIT = 31;
  localparam int PHY_CLOCK_GATE_BIT = 30;
  localparam int HOST_DISC_DET_BIT  = 1;
  localparam int PORT_SUSPEND_BIT   = 7;
  localparam int FORCE_RESUME_BIT   = 6;
  localparam int PHY_CLK_DIS_BIT    = 23;
  localparam int WAKE_DISC_BIT      = 21;
  localparam int WAKEUP_IRQ_EN_BIT  = 10;
  localparam logic [31:0] POWER_DOWN_ALL = 32'h001e_1c00;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 50;
  localparam int WAKE_DISC_WAIT_US = 300;
  localparam int WAKE_DISC_CYCLES  = (WAKE_DISC_WAIT_US * 1000) / CLK_PERIOD_NS;
  localparam int LOCK_TIMEOUT_CYC  = 2048;

  typedef enum logic [2:0] {
    CMD_NONE       = 3'h0,
    CMD_BRING_UP   = 3'h1,
    CMD_HOST_PORT_SUSPEND  = 3'h2,
    CMD_DEV_PORT_SUSPEND   = 3'h3,
    CMD_CPU_RESUME = 3'h4,
    CMD_WAKE_ACK   = 3'h5
  } upps_cmd_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [31:0] wdata;
  } upps_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } upps_rsp_t;

  typedef enum logic [15:0] {
    ST_IDLE      = 16'h0001,
    ST_BUS_CLK   = 16'h0002,
    ST_PLL_EN    = 16'h0004,
    ST_PLL_PWR   = 16'h0008,
    ST_PLL_LOCK  = 16'h0010,
    ST_PLL_BYP   = 16'h0020,
    ST_PLL_OUT   = 16'h0040,
    ST_PHY_RST   = 16'h0080,
    ST_PHY_UNGATE= 16'h0100,
    ST_PHY_REL   = 16'h0200,
    ST_PHY_PWRUP = 16'h0400,
    ST_PORT_SUSPEND_PREP = 16'h0800,
    ST_PORT_SUSPEND_POLL = 16'h1000,
    ST_LP_ENTER  = 16'h2000,
    ST_RES_POLL  = 16'h4000,
    ST_WAIT_IDLE = 16'h8000
  } upps_state_t;

endpackage

// ==== logic/upps_sequencer.sv ====
// upps_sequencer: host-side sequencer driving the usb pll, transceiver and port registers
// assumes the device answers each read or write with a one-cycle ack; inputs synchronous
`timescale 1ns/10ps
`default_nettype none

module upps_sequencer
  import upps_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  input  wire logic        i_cmd_valid,
  input  wire upps_cmd_t   i_cmd,
  input  wire logic        i_bus_idle_j,
  input  wire upps_rsp_t   i_dev_rsp,
  output logic             o_cmd_ready,
  output logic             o_done,
  output logic             o_error,
  output logic             o_low_power,
  output upps_req_t        o_dev_req
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  upps_state_t state_reg, state_next;
  upps_cmd_t   cmd_reg;
  upps_req_t   req_reg, req_next;
  logic        busy_reg;
  logic        done_reg, error_reg, lp_reg;
  logic [13:0] cnt_reg;

  function automatic upps_req_t mk_wr(input logic [3:0] a, input logic [31:0] d);
    upps_req_t r;
    r.wr    = 1'b1;
    r.rd    = 1'b0;
    r.addr  = a;
    r.wdata = d;
    return r;
  endfunction

  function automatic upps_req_t mk_rd(input logic [3:0] a);
    upps_req_t r;
    r.wr    = 1'b0;
    r.rd    = 1'b1;
    r.addr  = a;
    r.wdata = 32'h0000_0000;
    return r;
  endfunction

  function automatic logic [31:0] bit_of(input int n);
    return 32'h0000_0001 << n;
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic acked     = busy_reg & i_dev_rsp.ack;
  wire logic start     = (state_reg == ST_IDLE) & i_cmd_valid & ~busy_reg;
  wire logic lock_seen = i_dev_rsp.rdata[PLL_LOCK_BIT];
  wire logic port_suspend_seen = i_dev_rsp.rdata[PORT_SUSPEND_BIT];
  wire logic fpr_seen  = i_dev_rsp.rdata[FORCE_RESUME_BIT];
  wire logic cnt_full  = (cnt_reg == 14'(LOCK_TIMEOUT_CYC));
  wire logic wait_done = (cnt_reg == 14'(WAKE_DISC_CYCLES));

  // pll control values built up step by step
  wire logic [31:0] pll_en   = bit_of(PLL_ENABLE_BIT) | bit_of(PLL_BYPASS_BIT);
  wire logic [31:0] pll_pwr  = pll_en | bit_of(PLL_POWER_BIT);
  wire logic [31:0] pll_run  = bit_of(PLL_ENABLE_BIT) | bit_of(PLL_POWER_BIT);
  wire logic [31:0] pll_out  = pll_run | bit_of(PLL_CLK_OUT_EN_BIT);
  wire logic [31:0] phy_rst  = bit_of(PHY_SOFT_RESET_BIT) | bit_of(PHY_CLOCK_GATE_BIT);

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          case (i_cmd)
            CMD_BRING_UP: begin
              state_next = ST_BUS_CLK;
              req_next   = mk_wr(ADDR_CLOCK_GATE_REG_SIX, 32'(BUS_CLK_ON_TO_STOP));
            end
            CMD_HOST_PORT_SUSPEND, CMD_DEV_PORT_SUSPEND: begin
              state_next = ST_PORT_SUSPEND_PREP;
              // host: detector off first; device: suspend irq already seen by caller
              req_next   = (i_cmd == CMD_HOST_PORT_SUSPEND)
                           ? mk_wr(ADDR_PHY_CONTROL_REG, 32'h0000_0000)
                           : mk_wr(ADDR_PORT_STATUS_CTRL, bit_of(PHY_CLK_DIS_BIT));
            end
            CMD_CPU_RESUME: begin
              state_next = ST_PORT_SUSPEND_PREP;
              req_next   = mk_wr(ADDR_PORT_STATUS_CTRL, 32'h0000_0000);
            end
            CMD_WAKE_ACK: begin
              state_next = ST_PHY_PWRUP;
              req_next   = mk_wr(ADDR_USB_CTRL, 32'h0000_0000);
            end
            default: state_next = ST_IDLE;
          endcase
        end
      end
      ST_BUS_CLK:    if (acked) begin state_next = ST_PLL_EN;
                       req_next = mk_wr(ADDR_USB_PLL_CONTROL, pll_en); end
      ST_PLL_EN:     if (acked) begin state_next = ST_PLL_PWR;
                       req_next = mk_wr(ADDR_USB_PLL_CONTROL, pll_pwr); end
      ST_PLL_PWR:    if (acked) begin state_next = ST_PLL_LOCK; req_next = mk_rd(ADDR_USB_PLL_CONTROL); end
      ST_PLL_LOCK: begin
        if (acked & lock_seen) begin
          state_next = ST_PLL_BYP;
          req_next   = mk_wr(ADDR_USB_PLL_CONTROL, pll_run);
        end else if (cnt_full & acked) begin
          // give up only once the read in flight is answered
          state_next = ST_IDLE;
        end else if (acked) begin
          req_next = mk_rd(ADDR_USB_PLL_CONTROL);
        end
      end
      ST_PLL_BYP:    if (acked) begin state_next = ST_PLL_OUT;
                       req_next = mk_wr(ADDR_USB_PLL_CONTROL, pll_out); end
      ST_PLL_OUT:    if (acked) begin state_next = ST_PHY_RST;
                       req_next = mk_wr(ADDR_PHY_CONTROL_REG, phy_rst); end
      ST_PHY_RST:    if (acked) begin state_next = ST_PHY_UNGATE;
                       req_next = mk_wr(ADDR_PHY_CONTROL_REG, bit_of(PHY_SOFT_RESET_BIT)); end
      ST_PHY_UNGATE: if (acked) begin state_next = ST_PHY_REL;
                       req_next = mk_wr(ADDR_PHY_CONTROL_REG, bit_of(HOST_DISC_DET_BIT)); end
      ST_PHY_REL:    if (acked) begin state_next = ST_PHY_PWRUP;
                       req_next = mk_wr(ADDR_PHY_POWER_DOWN_REG, 32'h0000_0000); end
      ST_PHY_PWRUP:  if (acked) state_next = ST_IDLE;
      ST_PORT_SUSPEND_PREP: begin
        if (acked) begin
          case (cmd_reg)
            CMD_HOST_PORT_SUSPEND: begin
              state_next = ST_PORT_SUSPEND_POLL;
              req_next   = mk_wr(ADDR_PORT_STATUS_CTRL, bit_of(PORT_SUSPEND_BIT));
            end
            CMD_DEV_PORT_SUSPEND: begin
              state_next = ST_LP_ENTER;
              req_next   = mk_wr(ADDR_PHY_POWER_DOWN_REG, POWER_DOWN_ALL);
            end
            default: begin
              state_next = ST_RES_POLL;
              req_next   = mk_wr(ADDR_PORT_STATUS_CTRL, bit_of(FORCE_RESUME_BIT));
            end
          endcase
        end
      end
      ST_PORT_SUSPEND_POLL: begin
        if (acked) begin
          if (req_reg.rd & port_suspend_seen) begin
            state_next = ST_LP_ENTER;
            req_next   = mk_wr(ADDR_PORT_STATUS_CTRL, bit_of(PORT_SUSPEND_BIT) | bit_of(PHY_CLK_DIS_BIT));
          end else begin
            req_next   = mk_rd(ADDR_PORT_STATUS_CTRL);
          end
        end
      end
      ST_LP_ENTER: begin
        if (acked) begin
          if (req_reg.addr == ADDR_PORT_STATUS_CTRL && !req_reg.wdata[WAKE_DISC_BIT] && cmd_reg == CMD_HOST_PORT_SUSPEND)
            req_next = mk_wr(ADDR_PHY_POWER_DOWN_REG, POWER_DOWN_ALL);
          else if (req_reg.addr == ADDR_PHY_POWER_DOWN_REG)
            req_next = mk_wr(ADDR_PHY_CONTROL_REG, bit_of(PHY_CLOCK_GATE_BIT));
          else if (req_reg.addr == ADDR_PHY_CONTROL_REG)
            req_next = mk_wr(ADDR_USB_CTRL, bit_of(WAKEUP_IRQ_EN_BIT));
          else if (cmd_reg == CMD_HOST_PORT_SUSPEND && req_reg.addr == ADDR_USB_CTRL)
            state_next = ST_WAIT_IDLE;
          else
            state_next = ST_IDLE;
        end
      end
      ST_WAIT_IDLE: begin
        if (wait_done & ~busy_reg) begin
          state_next = ST_LP_ENTER;
          req_next   = mk_wr(ADDR_PORT_STATUS_CTRL, bit_of(PORT_SUSPEND_BIT) | bit_of(PHY_CLK_DIS_BIT)
                             | bit_of(WAKE_DISC_BIT));
        end
      end
      ST_RES_POLL: begin
        if (acked) begin
          if (req_reg.rd & ~fpr_seen) begin
            state_next = ST_PHY_PWRUP;
            req_next   = mk_wr(ADDR_PHY_CONTROL_REG, bit_of(HOST_DISC_DET_BIT));
          end else begin
            req_next   = mk_rd(ADDR_PORT_STATUS_CTRL);
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // request goes out when a new one is loaded, drops on ack
  wire logic issue = ((state_next != ST_IDLE) & (state_next != ST_WAIT_IDLE)
                      & (start | acked) & ~(state_reg == ST_PHY_PWRUP & acked)
                      & ~(state_reg == ST_LP_ENTER & state_next != ST_LP_ENTER))
                     | ((state_reg == ST_WAIT_IDLE) & (state_next == ST_LP_ENTER));
  wire logic finish = (state_reg != ST_IDLE) & (state_next == ST_IDLE);
  wire logic fail   = (state_reg == ST_PLL_LOCK) & cnt_full & acked & ~lock_seen;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= ST_IDLE;
      cmd_reg   <= CMD_NONE;
      req_reg   <= '0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
      error_reg <= 1'b0;
      lp_reg    <= 1'b0;
    end else if (i_ce) begin
      state_reg <= state_next;
      req_reg   <= req_next;
      if (acked & ~issue) begin
        req_reg.wr <= 1'b0;
        req_reg.rd <= 1'b0;
      end
      busy_reg  <= issue | (busy_reg & ~i_dev_rsp.ack & ~fail);
      done_reg  <= finish & ~fail;
      if (start) begin
        cmd_reg   <= i_cmd;
        error_reg <= 1'b0;
      end
      if (fail)
        error_reg <= 1'b1;
      if (finish & ~fail)
        lp_reg <= (cmd_reg == CMD_HOST_PORT_SUSPEND) | (cmd_reg == CMD_DEV_PORT_SUSPEND);
    end
  end

  // lock timeout and 300 us idle wait share one counter
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst)
      cnt_reg <= 14'h0000;
    else if (i_ce) begin
      if (state_reg == ST_PLL_LOCK)
        cnt_reg <= cnt_full ? cnt_reg : cnt_reg + 14'h0001;
      else if (state_reg == ST_WAIT_IDLE && i_bus_idle_j)
        cnt_reg <= wait_done ? cnt_reg : cnt_reg + 14'h0001;
      else
        cnt_reg <= 14'h0000;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  logic ready_reg;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst)
      ready_reg <= 1'b0;
    else if (i_ce)
      ready_reg <= (state_next == ST_IDLE) & ~issue;
  end

  assign o_cmd_ready = ready_reg;
  assign o_done      = done_reg;
  assign o_error     = error_reg;
  assign o_low_power = lp_reg;
  assign o_dev_req   = req_reg;

endmodule

`default_nettype wire

// ==== verification/upps_chk.sv ====
// upps_chk: register traffic checks on the sequencer ports
// assumes one clock and a device ack lasting one cycle
`timescale 1ns/10ps
`default_nettype none
module upps_chk
  import upps_pkg::*;
(
  input wire logic      i_core_clk,
  input wire logic      i_nrst,
  input wire logic      i_ce,
  input wire logic      i_cmd_valid,
  input wire upps_cmd_t i_cmd,
  input wire logic      i_bus_idle_j,
  input wire upps_rsp_t i_dev_rsp,
  input wire logic      o_cmd_ready,
  input wire logic      o_done,
  input wire logic      o_error,
  input wire logic      o_low_power,
  input wire upps_req_t o_dev_req
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  wire         wr     = o_dev_req.wr;
  wire         rk     = o_dev_req.rd & i_dev_rsp.ack;
  wire         wa     = wr & i_dev_rsp.ack;
  wire [3:0]   ad     = o_dev_req.addr;
  wire [31:0]  wd     = o_dev_req.wdata;
  wire         pll_w  = wr && ad == ADDR_USB_PLL_CONTROL;
  wire         port_w = wr && ad == ADDR_PORT_STATUS_CTRL;
  logic        lock_seen;
  logic        det_off;
  logic        gated;
  logic        fpr_pend;
  logic [12:0] idle_cnt;
  // --------------------
  // progress trackers
  // --------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      {lock_seen, det_off, gated, fpr_pend} <= 4'h0;
      idle_cnt <= 13'h0;
    end else begin
      idle_cnt <= i_bus_idle_j ? idle_cnt + 13'(idle_cnt != 13'h1fff) : 13'h0;
      if (rk && ad == ADDR_USB_PLL_CONTROL) lock_seen <= i_dev_rsp.rdata[PLL_LOCK_BIT];
      if (rk && ad == ADDR_PORT_STATUS_CTRL) fpr_pend <= fpr_pend & i_dev_rsp.rdata[FORCE_RESUME_BIT];
      if (wa && ad == ADDR_PORT_STATUS_CTRL) fpr_pend <= wd[FORCE_RESUME_BIT];
      if (wa && ad == ADDR_PHY_CONTROL_REG) {det_off, gated} <= {!wd[HOST_DISC_DET_BIT], wd[PHY_CLOCK_GATE_BIT]};
    end
  end
  sequence s_phy_clock_disable_set;
    wa && ad == ADDR_PORT_STATUS_CTRL && wd[PHY_CLK_DIS_BIT] && !wd[WAKE_DISC_BIT];
  endsequence
  sequence s_pwd_then_gate;
    ##[1:10] (wa && ad == ADDR_PHY_POWER_DOWN_REG && wd == POWER_DOWN_ALL)
    ##[1:10] (wr && ad == ADDR_PHY_CONTROL_REG && wd[PHY_CLOCK_GATE_BIT]);
  endsequence
  property p_req_hold;
    (wr | o_dev_req.rd) & !i_dev_rsp.ack |=> $stable(o_dev_req);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request moved before ack");
  property p_pwr_en;
    pll_w && wd[PLL_POWER_BIT] |-> wd[PLL_ENABLE_BIT];
  endproperty
  a_pwr_en: assert property (p_pwr_en) else $error("pll power without enable");
  property p_unbypass;
    pll_w && !wd[PLL_BYPASS_BIT] |-> lock_seen && wd[PLL_POWER_BIT];
  endproperty
  a_unbypass: assert property (p_unbypass) else $error("bypass cleared before lock");
  property p_port_suspend_det_off;
    port_w && wd[PORT_SUSPEND_BIT] |-> det_off;
  endproperty
  a_port_suspend_det_off: assert property (p_port_suspend_det_off) else $error("suspend with detector on");
  property p_pd_after_phy_clock_disable;
    s_phy_clock_disable_set |-> s_pwd_then_gate;
  endproperty
  a_pd_after_phy_clock_disable: assert property (p_pd_after_phy_clock_disable) else $error("no power-down and gate");
  property p_wake_wait;
    port_w && wd[WAKE_DISC_BIT] |-> idle_cnt >= WAKE_DISC_CYCLES;
  endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wake on disconnect too early");
  property p_wie_gate;
    wr && ad == ADDR_USB_CTRL && wd[WAKEUP_IRQ_EN_BIT] |-> gated;
  endproperty
  a_wie_gate: assert property (p_wie_gate) else $error("wakeup irq before low power");
  property p_det_resume;
    wr && ad == ADDR_PHY_CONTROL_REG && wd[HOST_DISC_DET_BIT] |-> !fpr_pend;
  endproperty
  a_det_resume: assert property (p_det_resume) else $error("detector on during resume");
endmodule
bind upps_sequencer upps_chk u_chk (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_ce(i_ce),
  .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_bus_idle_j(i_bus_idle_j), .i_dev_rsp(i_dev_rsp),
  .o_cmd_ready(o_cmd_ready), .o_done(o_done), .o_error(o_error), .o_low_power(o_low_power),
  .o_dev_req(o_dev_req));
`default_nettype wire

// ==== verification/upps_dev_model.sv ====
// upps_dev_model: pll, transceiver and port registers answering the sequencer
// assumes one access at a time; i_lat adds wait cycles before each ack
`timescale 1ns/10ps
`default_nettype none
module upps_dev_model
  import upps_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_nrst,
  input  wire upps_req_t   i_req,
  input  wire logic [1:0]  i_lat,
  input  wire logic        i_lock_ok,
  input  wire logic        i_wakeup,
  output upps_rsp_t        o_rsp,
  output logic [5:0][31:0] o_regs,
  output logic             o_pll_lp,
  output logic             o_phy_clk
);
  logic [1:0] wait_cnt;
  logic [3:0] port_suspend_cnt;
  logic [3:0] fpr_cnt;
  wire        busy   = (i_req.wr | i_req.rd) & !o_rsp.ack;
  wire        go     = busy & (wait_cnt >= i_lat);
  wire [3:0]  ad     = i_req.addr;
  wire [31:0] wd     = i_req.wdata;
  wire [31:0] cur    = o_regs[ad[2:0]];
  wire        locked = i_lock_ok & o_regs[1][PLL_ENABLE_BIT] & o_regs[1][PLL_POWER_BIT];
  wire        wr_ok  = i_req.wr & (!o_regs[2][PHY_CLOCK_GATE_BIT] | ad != ADDR_PHY_POWER_DOWN_REG);
  wire [31:0] rd_wd  = ad == ADDR_USB_PLL_CONTROL ? {locked, cur[30:0]} :
                       ad == ADDR_PORT_STATUS_CTRL && port_suspend_cnt != 4'h0 ? cur & ~32'h80 : cur;
  assign o_pll_lp  = o_regs[4][PHY_CLK_DIS_BIT];
  assign o_phy_clk = o_regs[1][PLL_CLK_OUT_EN_BIT] & !o_regs[1][PLL_BYPASS_BIT] & locked;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_regs <= '0;
      o_regs[1] <= 32'h0001_0000;
      o_regs[2] <= 32'hc000_0000;
      o_regs[3] <= POWER_DOWN_ALL;
      o_rsp <= '0;
      {wait_cnt, port_suspend_cnt, fpr_cnt} <= '0;
    end else begin
      o_rsp.ack <= go;
      o_rsp.rdata <= go && i_req.rd ? rd_wd : ~o_rsp.rdata;
      wait_cnt <= busy && !go ? wait_cnt + 2'h1 : 2'h0;
      port_suspend_cnt <= port_suspend_cnt - 4'(port_suspend_cnt != 4'h0);
      fpr_cnt <= fpr_cnt - 4'(fpr_cnt != 4'h0);
      if (fpr_cnt == 4'h1) o_regs[4][FORCE_RESUME_BIT] <= 1'b0;
      if (go && wr_ok) begin
        o_regs[ad[2:0]] <= wd;
        if (ad == ADDR_PORT_STATUS_CTRL) begin
          if (wd[PORT_SUSPEND_BIT] && !cur[PORT_SUSPEND_BIT]) port_suspend_cnt <= 4'h9;
          if (wd[FORCE_RESUME_BIT]) fpr_cnt <= 4'hc;
          if (!wd[PHY_CLK_DIS_BIT] && cur[PHY_CLK_DIS_BIT]) begin
            o_regs[2][PHY_CLOCK_GATE_BIT] <= 1'b0;
            o_regs[3] <= '0;
          end
        end
      end
      if (i_wakeup) begin
        o_regs[4][PHY_CLK_DIS_BIT] <= 1'b0;
        o_regs[2][PHY_CLOCK_GATE_BIT] <= 1'b0;
        o_regs[3] <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// tb_top: runs the sequencer against the device model and checks the register state
// assumes package, design, model and checker compiled before this file
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import upps_pkg::*;
;
  typedef struct packed {
    upps_cmd_t   cmd;
    logic        wake;
    logic [1:0]  lat;
    logic        lp;
    logic        slow;
    logic [31:0] ctrl;
    logic [31:0] power_down_bits;
    logic [31:0] port;
    logic [31:0] irq;
  } upps_tb_row_t;
  upps_tb_row_t     rows [5];
  logic             clk, nrst, ce, cmd_valid, idle_j, lock_ok, wakeup;
  logic             ready, done, err, lp, pll_lp, phy_clk;
  logic [1:0]       lat;
  upps_cmd_t        cmd;
  upps_rsp_t        rsp;
  upps_req_t        req;
  logic [5:0][31:0] regs;
  int               error_cnt, checks_done, cyc;
  upps_sequencer dut (.i_core_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_bus_idle_j(idle_j), .i_dev_rsp(rsp), .o_cmd_ready(ready), .o_done(done), .o_error(err),
    .o_low_power(lp), .o_dev_req(req));
  upps_dev_model dev (.i_core_clk(clk), .i_nrst(nrst), .i_req(req), .i_lat(lat), .i_lock_ok(lock_ok),
    .i_wakeup(wakeup), .o_rsp(rsp), .o_regs(regs), .o_pll_lp(pll_lp), .o_phy_clk(phy_clk));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic results;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run(input upps_cmd_t c);
    int n;
    n = 0;
    cyc = 0;
    while (ready !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    cmd = c;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && err !== 1'b1 && cyc < 9000) begin
      tick(1);
      cyc++;
    end
    if (n >= 100 || cyc >= 9000) begin
      chk("command_timeout", 32'h0, 32'h1);
      results();
    end
  endtask
  initial begin
    {nrst, ce, cmd_valid, idle_j, lock_ok, wakeup} = 6'b010010;
    cmd = CMD_NONE;
    lat = 2'h0;
    error_cnt = 0;
    checks_done = 0;
    rows[0] = '{CMD_BRING_UP, 1'b0, 2'h0, 1'b0, 1'b0, 32'h2, 32'h0, 32'h0, 32'h0};
    rows[1] = '{CMD_HOST_PORT_SUSPEND, 1'b0, 2'h1, 1'b1, 1'b1, 32'h4000_0000, POWER_DOWN_ALL, 32'h00a0_0080, 32'h400};
    rows[2] = '{CMD_CPU_RESUME, 1'b0, 2'h2, 1'b0, 1'b0, 32'h2, 32'h0, 32'h0, 32'h400};
    rows[3] = '{CMD_DEV_PORT_SUSPEND, 1'b0, 2'h3, 1'b1, 1'b0, 32'h4000_0000, POWER_DOWN_ALL, 32'h0080_0000, 32'h400};
    rows[4] = '{CMD_WAKE_ACK, 1'b1, 2'h0, 1'b0, 1'b0, 32'h0, 32'h0, 32'h0, 32'h0};
    tick(6);
    nrst = 1'b1;
    tick(2);
    foreach (rows[k]) begin
      lat = rows[k].lat;
      idle_j = rows[k].cmd == CMD_HOST_PORT_SUSPEND;
      if (rows[k].wake) begin
        wakeup = 1'b1;
        tick(1);
        wakeup = 1'b0;
        chk("wake_clear", 32'h0, regs[2] | regs[3] | {8'h0, regs[4][PHY_CLK_DIS_BIT], 23'h0});
      end
      run(rows[k].cmd);
      chk("bus_clk", 32'h3, regs[0]);
      chk("pll", 32'h0000_3040, regs[1]);
      chk("phy_ctrl", rows[k].ctrl, regs[2]);
      chk("pwd", rows[k].power_down_bits, regs[3]);
      chk("port", rows[k].port, regs[4]);
      chk("wake_irq", rows[k].irq, regs[5]);
      chk("pll_lp", {31'h0, rows[k].lp}, {31'h0, pll_lp});
      chk("low_power", {31'h0, rows[k].lp}, {31'h0, lp});
      chk("idle_wait", {31'h0, rows[k].slow}, {31'h0, cyc >= WAKE_DISC_CYCLES});
    end
    // reset in the middle of a suspend sequence
    idle_j = 1'b1;
    cmd = CMD_HOST_PORT_SUSPEND;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    tick(40);
    nrst = 1'b0;
    tick(1);
    chk("reset_outs", 32'h0, {26'h0, ready, done, err, lp, req.wr, req.rd});
    nrst = 1'b1;
    tick(1);
    chk("ready_after_reset", 32'h1, {31'h0, ready});
    // an empty command is taken and ignored
    cmd = CMD_NONE;
    cmd_valid = 1'b1;
    tick(1);
    cmd_valid = 1'b0;
    chk("none_ignored", 32'h1, {31'h0, ready & ~req.wr & ~req.rd});
    // pll never locks, then locks
    lock_ok = 1'b0;
    lat = 2'h3;
    run(CMD_BRING_UP);
    chk("lock_error", 32'h1, {31'h0, err});
    chk("bypass_kept", 32'h1, {31'h0, regs[1][PLL_BYPASS_BIT]});
    lock_ok = 1'b1;
    run(CMD_BRING_UP);
    chk("error_cleared", 32'h0, {31'h0, err});
    chk("phy_clk", 32'h1, {31'h0, phy_clk});
    chk("pwd_up", 32'h0, regs[3]);
    // clock enable low freezes the sequencer
    ce = 1'b0;
    cmd = CMD_WAKE_ACK;
    cmd_valid = 1'b1;
    tick(1);
    chk("ce_freeze", 32'h1, {31'h0, ready & ~req.wr});
    cmd_valid = 1'b0;
    ce = 1'b1;
    tick(1);
    results();
  end
endmodule
`default_nettype wire
